// ### verilog/ssr_status_regs.sv
// Safety self-test and watchdog failure status registers.
// Assumes decoded read/write strobes from the serial command decoder, one cycle each,
// and monitor inputs that are levels synchronous to clk_sys; bad events are pulses.
`timescale 1ns/10ps
module ssr_status_regs (
  // Clock, power-on reset and clock enable.
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Register access strobes from the command decoder.
  input wire logic read_clock_test_status_cmd,
  input wire logic read_logic_test_status_cmd,
  input wire logic read_watchdog_status_cmd,
  input wire logic write_fail_counter_cmd,
  input wire logic [7:0] wr_data,
  // Read answer.
  output logic [7:0] rd_data,
  output logic rd_valid,
  // Clock monitor self-test results (levels, 1 = error).
  input wire logic digital_sysclk_monitor_test_error,
  input wire logic boost_switch_clock_test_error,
  input wire logic buck_two_switch_clock_test_error,
  input wire logic buck_one_switch_clock_test_error,
  input wire logic source_clock_monitor_test_error,
  input wire logic sync_input_monitor_test_error,
  input wire logic analog_sysclk_monitor_test_error,
  // Logic self-test and diagnostic results (levels).
  input wire logic config_checksum_diag_error,
  input wire logic nvm_checksum_diag_error,
  input wire logic reset_monitor_diag_error,
  input wire logic drive_irq_pin_diag_error,
  input wire logic logic_test_run_error,
  input wire logic logic_test_core_error,
  input wire logic logic_test_complete,
  // Watchdog engine and device state.
  input wire logic watchdog_bad_event,
  input wire logic system_reset_event,
  input wire logic logic_test_start,
  input wire logic watchdog_config_change,
  input wire logic diagnostic_state,
  input wire logic config_lock,
  input wire logic [3:0] drive_failure_threshold,
  input wire logic [3:0] reset_failure_threshold,
  // Live watchdog status for the safety logic.
  output logic [3:0] watchdog_fail_counter,
  output logic watchdog_failure_flag,
  output logic watchdog_drive_failure_flag,
  output logic watchdog_reset_failure_flag
);
  // Flag counts of the three banks, taken from the package so the layouts live in one place.
  localparam int CF = ssr_pkg::CLK_FLAGS;
  localparam int LF = ssr_pkg::LST_FLAGS;
  localparam int WF = ssr_pkg::WD_FLAGS;

  // One carrier and one flag bank per register. Keeping the banks identical means the
  // latch, clear and init priority is written once and cannot drift between registers.
  ssr_flag_if #(.W(CF)) clk_fb ();
  ssr_flag_if #(.W(LF)) lst_fb ();
  ssr_flag_if #(.W(WF)) wd_fb ();

  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] rd_data_r;
  logic rd_valid_r;
  logic wd_init;
  logic cnt_wr_ok;

  // Threshold compare shared by the drive and reset failure flags.
  function automatic logic at_or_above(input logic [3:0] count, input logic [3:0] limit);
    return count >= limit;
  endfunction

  // Clock monitor self-test flags; init only by power-on reset and reads.
  assign clk_fb.cond[ssr_pkg::CLK_SYSCLK_DIGITAL_BIT] =
    digital_sysclk_monitor_test_error;
  assign clk_fb.cond[ssr_pkg::CLK_SOURCE_BIT] = source_clock_monitor_test_error;
  assign clk_fb.cond[ssr_pkg::CLK_SYNC_IN_BIT] = sync_input_monitor_test_error;
  assign clk_fb.cond[ssr_pkg::CLK_SYSCLK_ANALOG_BIT] =
    analog_sysclk_monitor_test_error;
  assign clk_fb.cond[ssr_pkg::CLK_BOOST_BIT] = boost_switch_clock_test_error;
  assign clk_fb.cond[ssr_pkg::CLK_BUCK_TWO_BIT] = buck_two_switch_clock_test_error;
  assign clk_fb.cond[ssr_pkg::CLK_BUCK_ONE_BIT] = buck_one_switch_clock_test_error;
  assign clk_fb.init_req = '0;
  assign clk_fb.rd = read_clock_test_status_cmd;

  // Logic self-test flags; the same init sources as the clock register.
  assign lst_fb.cond[ssr_pkg::LST_CFG_CRC_BIT] = config_checksum_diag_error;
  assign lst_fb.cond[ssr_pkg::LST_NVM_CRC_BIT] = nvm_checksum_diag_error;
  assign lst_fb.cond[ssr_pkg::LST_RESET_MON_BIT] = reset_monitor_diag_error;
  assign lst_fb.cond[ssr_pkg::LST_PIN_DIAG_BIT] = drive_irq_pin_diag_error;
  assign lst_fb.cond[ssr_pkg::LST_RUN_ERR_BIT] = logic_test_run_error;
  // Core error already folds in watchdog, reset supervisor and error-monitor checks.
  assign lst_fb.cond[ssr_pkg::LST_CORE_ERR_BIT] = logic_test_core_error;
  assign lst_fb.cond[ssr_pkg::LST_COMPLETE_BIT] = logic_test_complete;
  assign lst_fb.init_req = '0;
  assign lst_fb.rd = read_logic_test_status_cmd;

  // Watchdog flags. The failure flag's condition is the event pulse itself, so a read
  // clears it unless a new bad event lands in the same cycle.
  // The drive and reset flags compare the registered counter and so trail it by one edge.
  assign wd_init = system_reset_event | logic_test_start | watchdog_config_change;
  assign wd_fb.cond[ssr_pkg::WDF_FAIL] = watchdog_bad_event;
  assign wd_fb.cond[ssr_pkg::WDF_DRIVE] = at_or_above(cnt_r, drive_failure_threshold);
  assign wd_fb.cond[ssr_pkg::WDF_RESET] = at_or_above(cnt_r, reset_failure_threshold);
  assign wd_fb.init_req[ssr_pkg::WDF_FAIL] = wd_init;
  assign wd_fb.init_req[ssr_pkg::WDF_DRIVE] = wd_init;
  // A system reset must not hide that the watchdog caused it.
  assign wd_fb.init_req[ssr_pkg::WDF_RESET] = logic_test_start | watchdog_config_change;
  assign wd_fb.rd = read_watchdog_status_cmd;

  // All three banks share the clock, the power-on reset and the enable.
  ssr_flag_bank #(.W(CF), .INIT(ssr_pkg::CLK_INIT)) u_clk_flags (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .fb(clk_fb)
  );

  ssr_flag_bank #(.W(LF), .INIT(ssr_pkg::LST_INIT)) u_lst_flags (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .fb(lst_fb)
  );

  ssr_flag_bank #(.W(WF), .INIT(ssr_pkg::WD_INIT)) u_wd_flags (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .fb(wd_fb)
  );

  // Counter next value: init beats a write, a write beats an increment.
  // The increment saturates so a stuck watchdog cannot wrap back below a threshold.
  assign cnt_wr_ok = write_fail_counter_cmd & diagnostic_state & ~config_lock;
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (wd_init)
      cnt_nxt = drive_failure_threshold;
    else if (cnt_wr_ok)
      cnt_nxt = wr_data[ssr_pkg::WD_CNT_LSB +: ssr_pkg::CNT_W];
    else if (watchdog_bad_event && cnt_r != ssr_pkg::CNT_MAX)
      cnt_nxt = cnt_r + 4'h1;
  end

  // The power-on value is the drive threshold, caught on the first enabled cycle.
  // Limitation: a bad event in that very first enabled cycle is not counted, because
  // the cycle is spent loading the threshold.
  logic cnt_loaded_r;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= 4'h0;
      cnt_loaded_r <= 1'b0;
    end
    else if (ce)
    begin
      cnt_loaded_r <= 1'b1;
      cnt_r <= cnt_loaded_r ? cnt_nxt : drive_failure_threshold;
    end
  end

  // Read answer: the value before the read's clearing, bit 7 always zero.
  // Strobes are one-hot from the decoder; if two ever collided, both banks would clear
  // but only the higher-priority register would be reported, so they must never merge.
  // A strobe taken while ce is low is lost, not delayed: the host has to repeat it.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rd_data_r <= 8'h00;
      rd_valid_r <= 1'b0;
    end
    else if (ce)
    begin
      rd_valid_r <= read_clock_test_status_cmd | read_logic_test_status_cmd |
                    read_watchdog_status_cmd;
      if (read_clock_test_status_cmd)
        rd_data_r <= {1'b0, clk_fb.q};
      else if (read_logic_test_status_cmd)
        rd_data_r <= {1'b0, lst_fb.q};
      else if (read_watchdog_status_cmd)
        rd_data_r <= {1'b0, wd_fb.q, cnt_r};
    end
  end

  // Live watchdog status mirrors, straight from the flag and counter flops.
  // A clearing read shows on these mirrors one edge after its strobe, at the same edge
  // at which rd_data presents the word as it stood before the clear.
  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;
  assign watchdog_fail_counter = cnt_r;
  assign watchdog_failure_flag = wd_fb.q[ssr_pkg::WDF_FAIL];
  assign watchdog_drive_failure_flag = wd_fb.q[ssr_pkg::WDF_DRIVE];
  assign watchdog_reset_failure_flag = wd_fb.q[ssr_pkg::WDF_RESET];
endmodule

// ### verilog/ssr_pkg.sv
// Package for the safety self-test status registers.
// Assumes the three read commands and the counter write arrive as decoded strobes.
package ssr_pkg;
  localparam int REG_W = 8;
  localparam int CNT_W = 4;
  // Clock-monitor self-test status bit positions.
  localparam int CLK_SYSCLK_ANALOG_BIT = 0;
  localparam int CLK_SYNC_IN_BIT = 1;
  localparam int CLK_SOURCE_BIT = 2;
  localparam int CLK_BUCK_ONE_BIT = 3;
  localparam int CLK_BUCK_TWO_BIT = 4;
  localparam int CLK_BOOST_BIT = 5;
  localparam int CLK_SYSCLK_DIGITAL_BIT = 6;
  localparam int CLK_FLAGS = 7;
  // Logic self-test status bit positions.
  localparam int LST_COMPLETE_BIT = 0;
  localparam int LST_CORE_ERR_BIT = 1;
  localparam int LST_RUN_ERR_BIT = 2;
  localparam int LST_PIN_DIAG_BIT = 3;
  localparam int LST_RESET_MON_BIT = 4;
  localparam int LST_NVM_CRC_BIT = 5;
  localparam int LST_CFG_CRC_BIT = 6;
  localparam int LST_FLAGS = 7;
  // Watchdog error status layout: counter in bits 3..0, flags in bits 6..4.
  localparam int WD_CNT_LSB = 0;
  localparam int WATCHDOG_FAILURE_FLAG_BIT = 4;
  localparam int WD_DRIVE_FAIL_BIT = 5;
  localparam int WD_RESET_FAIL_BIT = 6;
  localparam int WD_FLAGS = 3;
  // Flag index inside the three-bit watchdog flag bank.
  localparam int WDF_FAIL = 0;
  localparam int WDF_DRIVE = 1;
  localparam int WDF_RESET = 2;
  // Initial values of the flag banks.
  localparam logic [CLK_FLAGS-1:0] CLK_INIT = 7'h00;
  localparam logic [LST_FLAGS-1:0] LST_INIT = 7'h00;
  localparam logic [WD_FLAGS-1:0] WD_INIT = 3'h2;
  localparam logic [CNT_W-1:0] CNT_MAX = 4'hf;
endpackage

// ### verilog/ssr_flag_if.sv
// Carrier between the status register top and its latched flag bank.
// Assumes both ends share clk_sys.
`timescale 1ns/10ps
interface ssr_flag_if #(parameter int W = 7);
  logic [W-1:0] cond;
  logic [W-1:0] init_req;
  logic rd;
  logic [W-1:0] q;
  modport ctrl (output cond, output init_req, output rd, input q);
  modport bank (input cond, input init_req, input rd, output q);
endinterface

// ### verilog/ssr_flag_bank.sv
// Bank of latch-until-read status flags.
// Assumes cond is the live level of each monitored condition, synchronous to clk_sys.
`timescale 1ns/10ps
module ssr_flag_bank #(
  parameter int W = 7,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock, reset and enable.
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Flag carrier.
  ssr_flag_if.bank fb
);
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // A present condition always sets the flag, so it beats a clearing read or an init.
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_flag
      assign q_nxt[i] = fb.cond[i] ? 1'b1 :
                        fb.init_req[i] ? INIT[i] :
                        (fb.rd ? 1'b0 : q_r[i]);
    end
  endgenerate

  // One register for the whole bank; ce freezes it.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      q_r <= INIT;
    else if (ce)
      q_r <= q_nxt;
  end

  assign fb.q = q_r;
endmodule

// ### tb/ssr_status_regs_chk.sv
// Checker on the top ports of the safety status registers.
// Assumes it is bound into the top module and sees its ports only.
`timescale 1ns/10ps
module ssr_status_regs_chk (
  // Clock, reset and enable.
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Register access strobes and write data.
  input wire logic read_clock_test_status_cmd,
  input wire logic read_logic_test_status_cmd,
  input wire logic read_watchdog_status_cmd,
  input wire logic write_fail_counter_cmd,
  input wire logic [7:0] wr_data,
  // Read answer.
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  // Watchdog engine and device state.
  input wire logic watchdog_bad_event,
  input wire logic system_reset_event,
  input wire logic logic_test_start,
  input wire logic watchdog_config_change,
  input wire logic diagnostic_state,
  input wire logic config_lock,
  input wire logic [3:0] drive_failure_threshold,
  input wire logic [3:0] reset_failure_threshold,
  // Live watchdog status.
  input wire logic [3:0] watchdog_fail_counter,
  input wire logic watchdog_failure_flag,
  input wire logic watchdog_drive_failure_flag,
  input wire logic watchdog_reset_failure_flag
);
  // Decoded causes; a write only counts when the diagnostic gate is open.
  wire logic init = system_reset_event | logic_test_start | watchdog_config_change;
  wire logic wr_ok = ce & write_fail_counter_cmd & diagnostic_state & ~config_lock;
  wire logic rd_cl = read_clock_test_status_cmd | read_logic_test_status_cmd;
  wire logic rd_any = ce & (rd_cl | read_watchdog_status_cmd);
  wire logic rd_wd = ce & read_watchdog_status_cmd & ~rd_cl;
  wire logic [3:0] cnt = watchdog_fail_counter;
  wire logic [2:0] wfl = {watchdog_reset_failure_flag, watchdog_drive_failure_flag,
    watchdog_failure_flag};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  answer_pulse_a: assert property (rd_any |=> rd_valid ##1
    (!rd_valid || $past(rd_any) || !$past(ce))) else $error("read answer timing wrong");
  wd_read_a: assert property (rd_wd |=> rd_data == {1'b0, $past(wfl), $past(cnt)})
    else $error("watchdog read data wrong");
  reserved_zero_a: assert property (rd_valid |-> !rd_data[7])
    else $error("reserved bit set");
  fail_set_a: assert property (ce && watchdog_bad_event |=> watchdog_failure_flag)
    else $error("failure flag not set");
  flag_hold_a: assert property (wfl[0] && !read_watchdog_status_cmd
    && !init |=> wfl[0]) else $error("failure flag lost without read");
  cnt_incr_a: assert property (ce && watchdog_bad_event && !init && !wr_ok
    && cnt != 4'hf |=> cnt == $past(cnt) + 4'h1) else $error("counter did not step");
  cnt_write_a: assert property (wr_ok && !init |=> cnt == $past(wr_data[3:0]))
    else $error("counter write lost");
  cnt_refuse_a: assert property (ce && write_fail_counter_cmd && !wr_ok && !init
    && !watchdog_bad_event |=> $stable(cnt)) else $error("refused write changed counter");
  wd_init_a: assert property (ce && init && !watchdog_bad_event |=> !wfl[0] && wfl[1]
    && cnt == $past(drive_failure_threshold)) else $error("watchdog init wrong");
  drive_th_a: assert property (ce && cnt >= drive_failure_threshold |=> wfl[1])
    else $error("drive flag not set");
  reset_th_a: assert property (ce && cnt >= reset_failure_threshold |=> wfl[2])
    else $error("reset flag not set");
  reset_keep_a: assert property (ce && system_reset_event && wfl[2]
    && !rd_any |=> wfl[2]) else $error("reset flag cleared by system reset");
  // Main scenarios reached.
  cover property (rd_wd ##1 rd_valid);
  cover property (wr_ok);
  cover property (ce && system_reset_event && wfl[2]);
  cover property (!ce && watchdog_bad_event);
endmodule
bind ssr_status_regs ssr_status_regs_chk chk (.*);

// ### tb/ssr_host.sv
// Host controller model issuing decoded register reads and counter writes.
// Assumes the block answers in the cycle after the strobe edge.
`timescale 1ns/10ps
module ssr_host (
  // Clock and read answer.
  input wire logic clk_sys,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  // Command strobes and write data.
  output logic read_clock_test_status_cmd,
  output logic read_logic_test_status_cmd,
  output logic read_watchdog_status_cmd,
  output logic write_fail_counter_cmd,
  output logic [7:0] wr_data
);
  logic [2:0] rs;
  // One-hot read strobes; selector 0 clock, 1 logic, 2 watchdog.
  assign {read_clock_test_status_cmd, read_logic_test_status_cmd, read_watchdog_status_cmd} = rs;
  initial
  begin
    rs = 3'h0;
    write_fail_counter_cmd = 1'b0;
    wr_data = 8'h00;
  end
  // Each read is one strobe cycle; callers repeat it to confirm a clear.
  task automatic rd(input int s, output logic [8:0] d);
    @(negedge clk_sys);
    rs = 3'h4 >> s;
    @(negedge clk_sys);
    d = {rd_valid, rd_data};
    rs = 3'h0;
  endtask
  // Counter write; data is inverted after use so stale data is never mistaken.
  task automatic wr(input logic [7:0] v);
    @(negedge clk_sys);
    write_fail_counter_cmd = 1'b1;
    wr_data = v;
    @(negedge clk_sys);
    write_fail_counter_cmd = 1'b0;
    wr_data = ~v;
  endtask
endmodule

// ### tb/ssr_status_regs_tb_top.sv
// Testbench for the safety status registers, reads and writes go through the host model.
// Assumes monitor levels and watchdog pulses are driven here at the falling edge.
`timescale 1ns/10ps
module ssr_status_regs_tb_top;
  logic clk_sys, rst, ce, bad, sre, lts, wcc, diag, lock, rd_valid, write_fail_counter_cmd;
  logic read_clock_test_status_cmd, read_logic_test_status_cmd, read_watchdog_status_cmd;
  logic [6:0] cm, lm;
  logic [3:0] dth, rth, wcnt;
  logic [2:0] wf;
  logic [7:0] wr_data, rd_data;
  logic [8:0] d;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  ssr_host host (.*);
  ssr_status_regs uut (.*, .digital_sysclk_monitor_test_error(cm[6]),
    .boost_switch_clock_test_error(cm[5]), .buck_two_switch_clock_test_error(cm[4]),
    .buck_one_switch_clock_test_error(cm[3]), .source_clock_monitor_test_error(cm[2]),
    .sync_input_monitor_test_error(cm[1]), .analog_sysclk_monitor_test_error(cm[0]),
    .config_checksum_diag_error(lm[6]), .nvm_checksum_diag_error(lm[5]),
    .reset_monitor_diag_error(lm[4]), .drive_irq_pin_diag_error(lm[3]),
    .logic_test_run_error(lm[2]), .logic_test_core_error(lm[1]), .logic_test_complete(lm[0]),
    .watchdog_bad_event(bad), .system_reset_event(sre), .logic_test_start(lts),
    .watchdog_config_change(wcc), .diagnostic_state(diag), .config_lock(lock),
    .drive_failure_threshold(dth), .reset_failure_threshold(rth),
    .watchdog_fail_counter(wcnt), .watchdog_failure_flag(wf[0]),
    .watchdog_drive_failure_flag(wf[1]), .watchdog_reset_failure_flag(wf[2]));
  // 50 MHz system clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Hang guard: the sequence needs about 150 cycles.
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt++;
      print_verdict();
    end
  end
  // Read one register and compare valid and data together.
  task automatic rdc(input int s, input string n, input logic [7:0] e);
    host.rd(s, d);
    cmp_count++;
    if (d !== {1'b1, e})
    begin
      $display("wrong value %s expected %h seen %h", n, {1'b1, e}, d);
      error_cnt++;
    end
  endtask
  // Compare a value seen outside the read task.
  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] s);
    cmp_count++;
    if (s !== e)
    begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      error_cnt++;
    end
  endtask
  // One-cycle event pulse.
  task automatic pulse(ref logic s);
    @(negedge clk_sys);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
  endtask
  // Each self-test flag latches and clears once gone; the logic flags also survive a read while present.
  task automatic t_selftest();
    for (int i = 0; i < 7; i++)
    begin
      cm[i] = 1'b1;
      lm[i] = 1'b1;
      @(negedge clk_sys);
      cm[i] = 1'b0;
      rdc(0, "clock reg", 8'h01 << i);
      rdc(0, "clock reg confirm", 8'h00);
      rdc(1, "logic reg held", 8'h01 << i);
      lm[i] = 1'b0;
      rdc(1, "logic reg clearing", 8'h01 << i);
      rdc(1, "logic reg confirm", 8'h00);
    end
  endtask
  // Bad events raise count and flags; system reset spares the reset-failure flag.
  task automatic t_watchdog();
    rdc(2, "wd after reset", 8'h25);
    repeat (3) pulse(bad);
    repeat (2) @(negedge clk_sys);
    chk("wd live status", 9'h078, {2'b00, wf, wcnt});
    rdc(2, "wd after events", 8'h78);
    pulse(sre);
    repeat (2) @(negedge clk_sys);
    rdc(2, "wd after system reset", 8'h65);
    rdc(2, "wd confirm", 8'h25);
  endtask
  // Counter writes only pass the diagnostic gate; self-test and config change init.
  task automatic t_write();
    host.wr(8'h03);
    diag = 1'b1;
    lock = 1'b1;
    host.wr(8'h03);
    repeat (2) @(negedge clk_sys);
    rdc(2, "wd write refused", 8'h25);
    lock = 1'b0;
    host.wr(8'hf2);
    repeat (2) @(negedge clk_sys);
    rdc(2, "wd written", 8'h22);
    rdc(2, "wd drive cleared", 8'h02);
    pulse(bad);
    pulse(lts);
    rdc(2, "wd self-test init", 8'h25);
    pulse(bad);
    pulse(wcc);
    rdc(2, "wd config init", 8'h25);
    // With the enable low, both a bad event and a read strobe must be dropped.
    @(negedge clk_sys);
    ce = 1'b0;
    pulse(bad);
    host.rd(2, d);
    chk("frozen read", 9'h025, d);
    ce = 1'b1;
    rdc(2, "wd after freeze", 8'h25);
  endtask
  // Counts, then the verdict; the one place the run ends.
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Main sequence after a 20-cycle power-on reset.
  initial
  begin
    {rst, ce, bad, sre, lts, wcc, diag, lock} = 8'hc0;
    {cm, lm, dth, rth} = {14'h0000, 4'h5, 4'h8};
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    repeat (2) @(negedge clk_sys);
    t_watchdog();
    t_selftest();
    t_write();
    print_verdict();
  end
endmodule
